// [hdl/two_wire_master_tx_rx_engine.sv]
// master transmit and receive engine of a byte-wide two-wire serial interface
// assumes a pull-up on both lines and software polling or using irq_o

module two_wire_master_tx_rx_engine (
	input  wire logic                                  core_clk_i,
	input  wire logic                                  rstn_i,
	input  wire logic                                  ce_i,
	input  wire logic [two_wire_engine_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [7:0]                            wdata_i,
	input  wire logic                                  wr_i,
	input  wire logic                                  rd_i,
	output logic      [7:0]                            rdata_o,
	input  wire logic                                  scl_i,
	output logic                                       scl_o,
	output logic                                       scl_oe_o,
	input  wire logic                                  sda_i,
	output logic                                       sda_o,
	output logic                                       sda_oe_o,
	output logic                                       irq_o
);
	import two_wire_engine_pkg::*;

	// ************************************
	// state
	// ************************************
	logic [1:0] scl_sy;
	logic [1:0] sda_sy;
	logic       sda_prev;
	logic       busy;
	state_t     st;
	logic [1:0] step;
	logic [3:0] bitn;
	logic [7:0] qcnt;
	logic       flag;
	logic       ea;
	logic       start_request;
	logic       stop_request;
	logic       wc;
	logic       en;
	logic       ie;
	logic [7:0] status;
	logic [7:0] data_reg;
	logic [7:0] shift;
	logic [7:0] rdata;
	logic       owned;
	logic       rx;
	logic       addr_ph;
	logic       ackd;
	logic       scl_drv;
	logic       sda_drv;

	// ************************************
	// decode
	// ************************************
	wire       scl_s    = scl_sy[1];
	wire       sda_s    = sda_sy[1];
	wire       start_sn = scl_s && sda_prev && !sda_s;
	wire       stop_sn  = scl_s && !sda_prev && sda_s;
	wire       wr_ctrl  = wr_i && (addr_i == ADDR_CONTROL);
	wire       wr_data  = wr_i && (addr_i == ADDR_DATA);
	wire       go       = wr_ctrl && wdata_i[BIT_INT];
	wire       w_sta    = wdata_i[BIT_STA];
	wire       w_sto    = wdata_i[BIT_STO];
	wire       w_en     = wdata_i[BIT_EN];
	wire       in_seq   = (st == S_START) || (st == S_BITS) || (st == S_STOP);
	wire       tick     = in_seq && (qcnt == 8'h00);
	// a slave stretching the clock holds the high phase back
	wire       adv      = tick && ((step != 2'd2) || scl_s);
	wire       tx_bit   = addr_ph || !rx;
	wire       mine     = (bitn == ACK_BIT) ? !tx_bit : tx_bit;
	wire       lost     = (st == S_BITS) && adv && (step == 2'd2) && mine && !sda_drv && !sda_s;
	wire       last     = (st == S_BITS) && adv && (step == 2'd3) && (bitn == ACK_BIT);
	wire       rx_next  = rx && ((status == ST_RX_A_ACK) || (status == ST_RX_D_ACK));
	wire       waiting  = (st == S_IDLE) || (st == S_HOLD);
	wire       run      = en || (go && w_en);
	wire [7:0] ctrl_rd  = {flag, ea, start_request, stop_request, wc, en, 1'b0, ie};
	wire [7:0] tx_code  = addr_ph ? (ackd ? ST_TX_A_ACK : ST_TX_A_NACK)
	                              : (ackd ? ST_TX_D_ACK : ST_TX_D_NACK);
	wire [7:0] rx_code  = addr_ph ? (ackd ? ST_RX_A_ACK : ST_RX_A_NACK)
	                              : (ackd ? ST_RX_D_ACK : ST_RX_D_NACK);
	wire [7:0] fin_code = rx ? rx_code : tx_code;
	wire [7:0] rd_mux   = (addr_i == ADDR_CONTROL) ? ctrl_rd :
	                      (addr_i == ADDR_STATUS)  ? status :
	                      (addr_i == ADDR_DATA)    ? data_reg : 8'h00;

	assign rdata_o  = rdata;
	assign scl_o    = 1'b0;
	assign sda_o    = 1'b0;
	assign scl_oe_o = scl_drv;
	assign sda_oe_o = sda_drv;
	assign irq_o    = flag && ie;

	// ************************************
	// pin sampling and bus watch
	// ************************************
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			scl_sy   <= 2'b11;
			sda_sy   <= 2'b11;
			sda_prev <= 1'b1;
			busy     <= 1'b0;
		end else if (ce_i) begin
			scl_sy   <= {scl_sy[0], scl_i};
			sda_sy   <= {sda_sy[0], sda_i};
			sda_prev <= sda_s;
			busy     <= start_sn || (busy && !stop_sn);
		end
	end

	// ************************************
	// software registers
	// ************************************
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			rdata <= 8'h00;
			ea    <= 1'b0;
			start_request   <= 1'b0;
			en    <= 1'b0;
			ie    <= 1'b0;
		end else if (ce_i) begin
			rdata <= rd_i ? rd_mux : 8'h00;
			if (wr_ctrl) begin
				ea  <= wdata_i[BIT_EA];
				start_request <= w_sta;
				en  <= w_en;
				ie  <= wdata_i[BIT_IE];
			end
		end
	end

	// ************************************
	// bus engine
	// ************************************
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			st       <= S_IDLE;
			step     <= 2'd0;
			bitn     <= 4'd0;
			qcnt     <= QUARTER_CYC;
			flag     <= 1'b0;
			stop_request      <= 1'b0;
			wc       <= 1'b0;
			status   <= ST_IDLE;
			data_reg <= DATA_RST;
			shift    <= 8'h00;
			owned    <= 1'b0;
			rx       <= 1'b0;
			addr_ph  <= 1'b0;
			ackd     <= 1'b0;
			scl_drv  <= 1'b0;
			sda_drv  <= 1'b0;
		end else if (ce_i) begin
			qcnt <= (in_seq && (qcnt != 8'h00)) ? qcnt - 8'h01 : QUARTER_CYC;
			if (adv) begin
				step <= step + 2'd1;
			end
			if (wr_ctrl) begin
				stop_request <= w_sto;
			end
			if (go) begin
				flag <= 1'b0;
			end
			if (wr_data) begin
				if (flag) begin
					data_reg <= wdata_i;
					wc       <= 1'b0;
				end else begin
					wc <= 1'b1;
				end
			end
			if (!en) begin
				st      <= S_IDLE;
				owned   <= 1'b0;
				scl_drv <= 1'b0;
				sda_drv <= 1'b0;
			end
			if (run) begin
				case (st)
				S_IDLE, S_HOLD: begin
					if (go && waiting) begin
						step <= 2'd0;
						bitn <= 4'd0;
						if (!owned) begin
							// lines stay released unless a new start is asked for
							st     <= w_sta ? S_WAIT : S_IDLE;
							status <= ST_IDLE;
						end else if (w_sto) begin
							st <= S_STOP;
						end else if (w_sta) begin
							st <= S_START;
						end else if ((status == ST_START) || (status == ST_RSTART)) begin
							st      <= S_BITS;
							shift   <= data_reg;
							addr_ph <= 1'b1;
							rx      <= data_reg[0];
						end else begin
							st      <= S_BITS;
							shift   <= data_reg;
							addr_ph <= 1'b0;
							rx      <= rx_next;
						end
					end
				end
				S_WAIT: begin
					if (!busy) begin
						st   <= S_START;
						step <= 2'd0;
					end
				end
				S_START: begin
					if (adv) begin
						case (step)
						2'd0: sda_drv <= 1'b0;
						2'd1: scl_drv <= 1'b0;
						2'd2: sda_drv <= 1'b1;
						default: begin
							scl_drv <= 1'b1;
							flag    <= 1'b1;
							status  <= owned ? ST_RSTART : ST_START;
							owned   <= 1'b1;
							st      <= S_HOLD;
						end
						endcase
					end
				end
				S_BITS: begin
					if (adv) begin
						case (step)
						2'd0: begin
							if (bitn == ACK_BIT) begin
								sda_drv <= !tx_bit && ea;
							end else begin
								sda_drv <= tx_bit && !shift[7];
							end
						end
						2'd1: scl_drv <= 1'b0;
						2'd2: begin
							if (bitn == ACK_BIT) begin
								ackd <= !sda_s;
							end else begin
								shift <= {shift[6:0], sda_s};
							end
							if (lost) begin
								// hand the bus over at once, other master continues
								st      <= S_IDLE;
								owned   <= 1'b0;
								sda_drv <= 1'b0;
								flag    <= 1'b1;
								status  <= ST_ARB;
							end
						end
						default: begin
							scl_drv <= 1'b1;
							if (bitn == ACK_BIT) begin
								flag    <= 1'b1;
								status  <= fin_code;
								addr_ph <= 1'b0;
								st      <= S_HOLD;
								if (rx && !addr_ph) begin
									data_reg <= shift;
								end
							end else begin
								bitn <= bitn + 4'd1;
							end
						end
						endcase
					end
				end
				S_STOP: begin
					if (adv) begin
						case (step)
						2'd0: sda_drv <= 1'b1;
						2'd1: scl_drv <= 1'b0;
						2'd2: sda_drv <= 1'b0;
						default: begin
							owned  <= 1'b0;
							stop_request    <= 1'b0;
							status <= ST_IDLE;
							st     <= start_request ? S_WAIT : S_IDLE;
						end
						endcase
					end
				end
				default: st <= S_IDLE;
				endcase
			end
		end
	end

	// ************************************
	// checks
	// ************************************
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rstn_i);

	property p_go_start;
		ce_i && en && st == S_IDLE && !owned && go && w_sta && w_en |=> st == S_WAIT;
	endproperty
	a_go_start: assert property (p_go_start) else $error("start request not taken");

	property p_flag_clear;
		ce_i && st == S_HOLD && go |=> !flag && !irq_o;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	property p_flag_keep;
		ce_i && flag && wr_ctrl && !wdata_i[BIT_INT] |=> flag;
	endproperty
	a_flag_keep: assert property (p_flag_keep) else $error("flag lost on zero write");

	property p_start_code;
		ce_i && st == S_START && adv && step == 2'd3 && !owned
			|=> flag && status == ST_START && st == S_HOLD;
	endproperty
	a_start_code: assert property (p_start_code) else $error("start code wrong");

	property p_mode;
		ce_i && en && st == S_HOLD && go && w_en && !w_sta && !w_sto && status == ST_RSTART
			|=> st == S_BITS && addr_ph && rx == data_reg[0];
	endproperty
	a_mode: assert property (p_mode) else $error("direction not taken");

	property p_rstart;
		ce_i && en && st == S_HOLD && owned && go && w_en && w_sta && !w_sto
			|=> st == S_START && owned && scl_oe_o;
	endproperty
	a_rstart: assert property (p_rstart) else $error("repeated start not begun");

	property p_stop;
		ce_i && en && st == S_STOP && adv && step == 2'd3 |=> !stop_request && !owned && !sda_oe_o;
	endproperty
	a_stop: assert property (p_stop) else $error("stop bit not cleared");

	property p_both;
		ce_i && en && st == S_HOLD && owned && go && w_en && w_sta && w_sto
			|=> st == S_STOP && start_request;
	endproperty
	a_both: assert property (p_both) else $error("stop then start not begun");

	property p_arb;
		ce_i && en && lost |=> flag && status == ST_ARB && !owned && !sda_oe_o && !scl_oe_o;
	endproperty
	a_arb: assert property (p_arb) else $error("arbitration loss mishandled");

	property p_rx_byte;
		ce_i && en && last && rx && !addr_ph |=> flag && data_reg == $past(shift);
	endproperty
	a_rx_byte: assert property (p_rx_byte) else $error("received byte missing");

	property p_hold;
		flag && owned |-> st == S_HOLD && scl_oe_o;
	endproperty
	a_hold: assert property (p_hold) else $error("bus not held");

	property p_wc;
		ce_i && wr_data && !flag |=> wc && $stable(data_reg);
	endproperty
	a_wc: assert property (p_wc) else $error("collision not flagged");

	property p_rx_next;
		ce_i && en && st == S_HOLD && owned && go && w_en && !w_sta && !w_sto && rx_next
			|=> st == S_BITS && rx && !addr_ph;
	endproperty
	a_rx_next: assert property (p_rx_next) else $error("next byte not received");

endmodule : two_wire_master_tx_rx_engine

// [hdl/two_wire_engine_pkg.sv]
// constants, register layout, status codes and states of the two-wire master engine
// assumes a 40 MHz core clock and an open-drain two-wire bus outside
package two_wire_engine_pkg;

	// ************************************
	// register map
	// ************************************
	localparam int             ADDR_W       = 2;
	localparam logic [1:0]     ADDR_CONTROL = 2'h0;
	localparam logic [1:0]     ADDR_STATUS  = 2'h1;
	localparam logic [1:0]     ADDR_DATA    = 2'h2;

	// control bit positions
	localparam int             BIT_INT      = 7;
	localparam int             BIT_EA       = 6;
	localparam int             BIT_STA      = 5;
	localparam int             BIT_STO      = 4;
	localparam int             BIT_WC       = 3;
	localparam int             BIT_EN       = 2;
	localparam int             BIT_IE       = 0;

	localparam logic [7:0]     DATA_RST     = 8'hff;

	// ************************************
	// status codes, low three bits zero
	// ************************************
	localparam logic [7:0]     ST_START     = 8'h08;
	localparam logic [7:0]     ST_RSTART    = 8'h10;
	localparam logic [7:0]     ST_TX_A_ACK  = 8'h18;
	localparam logic [7:0]     ST_TX_A_NACK = 8'h20;
	localparam logic [7:0]     ST_TX_D_ACK  = 8'h28;
	localparam logic [7:0]     ST_TX_D_NACK = 8'h30;
	localparam logic [7:0]     ST_ARB       = 8'h38;
	localparam logic [7:0]     ST_RX_A_ACK  = 8'h40;
	localparam logic [7:0]     ST_RX_A_NACK = 8'h48;
	localparam logic [7:0]     ST_RX_D_ACK  = 8'h50;
	localparam logic [7:0]     ST_RX_D_NACK = 8'h58;
	localparam logic [7:0]     ST_IDLE      = 8'hf8;

	// ************************************
	// timing
	// ************************************
	localparam int             QUARTER_NS   = 250;
	localparam int             CLK_MHZ      = 40;
	localparam int             QUARTER_INT  = (QUARTER_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0]     QUARTER_CYC  = 8'(QUARTER_INT);
	localparam logic [3:0]     ACK_BIT      = 4'h8;

	typedef enum logic [5:0] {
		S_IDLE  = 6'h01,
		S_WAIT  = 6'h02,
		S_START = 6'h04,
		S_BITS  = 6'h08,
		S_STOP  = 6'h10,
		S_HOLD  = 6'h20
	} state_t;

endpackage : two_wire_engine_pkg

// [verification/bus_slave_model.sv]
// slave device model for the two-wire bus, acks its own address
// assumes the bench resolves both open-drain lines with pull-ups
module bus_slave_model #(
	parameter logic [6:0] SLV_ADDR = 7'h2a
) (
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic [7:0] rd_byte_i,
	output logic            sda_oe_o,
	output logic [7:0]      last_byte_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int         cnt   = 0;
	logic       act   = 1'b0;
	logic       first = 1'b0;
	logic       hit   = 1'b0;
	logic       rdm   = 1'b0;
	logic       mack  = 1'b0;
	logic [7:0] sh    = 8'h00;
	logic [7:0] tx    = 8'h00;
	initial sda_oe_o = 1'b0;
	initial last_byte_o = 8'h00;
	// start or repeated start reopens the address phase
	always @(negedge sda_i) begin
		if (scl_i === 1'b1) begin
			act = 1'b1;
			first = 1'b1;
			cnt = 0;
		end
	end
	// stop frees the bus, so the line must be let go
	always @(posedge sda_i) begin
		if (scl_i === 1'b1) begin
			act = 1'b0;
			sda_oe_o = 1'b0;
		end
	end
	always @(posedge scl_i) begin
		if (act) begin
			if (cnt < 8) sh = {sh[6:0], sda_i};
			else mack = ~sda_i;
			cnt = cnt + 1;
		end
	end
	// line changes only while the clock line is low
	always @(negedge scl_i) begin
		if (act && cnt == 8) begin
			if (first) begin
				hit = (sh[7:1] == SLV_ADDR);
				rdm = sh[0];
				mack = 1'b1;
			end else if (!rdm) begin
				last_byte_o = sh;
			end
			sda_oe_o = hit && (first || !rdm);
			first = 1'b0;
		end else if (act && cnt == 9) begin
			cnt = 0;
			tx = rd_byte_i;
			sda_oe_o = hit && rdm && mack && !tx[7];
		end else if (act && cnt > 0 && hit && rdm && !first && mack) begin
			sda_oe_o = ~tx[7-cnt];
		end
	end
endmodule : bus_slave_model

// [verification/tb.sv]
// self-checking bench of the two-wire master engine
// assumes one slave model at 7'h2a and pull-ups on both lines
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import two_wire_engine_pkg::*;
	logic       core_clk_i = 1'b0;
	logic       rstn_i     = 1'b0;
	logic       wr_i       = 1'b0;
	logic       rd_i       = 1'b0;
	logic       tb_low     = 1'b0;
	logic [1:0] addr_i     = 2'h0;
	logic [7:0] wdata_i    = 8'h00;
	logic [7:0] rdata_o;
	logic [7:0] last_byte;
	logic [7:0] v;
	logic       scl_oe;
	logic       sda_oe;
	logic       slv_oe;
	logic       irq;
	wire        scl_line = ~scl_oe;
	wire        sda_line = ~(sda_oe | slv_oe | tb_low);
	int         fail_count = 0;
	int         cmp_count  = 0;
	localparam logic [7:0] RD_BYTE = 8'h96;

	always #12.5 core_clk_i = ~core_clk_i;

	two_wire_master_tx_rx_engine u_two_wire_master_tx_rx_engine (
		.core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.scl_i(scl_line), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_line),
		.sda_o(), .sda_oe_o(sda_oe), .irq_o(irq));
	bus_slave_model u_bus_slave_model (
		.scl_i(scl_line), .sda_i(sda_line), .rd_byte_i(RD_BYTE),
		.sda_oe_o(slv_oe), .last_byte_o(last_byte));

	// ****
	// bus and check tasks
	// ****
	task automatic conclude;
		$display("mismatches %0d compares %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	// polling only; a lost flag must not hang the run
	task automatic wait_bit(input int b, input logic lvl);
		for (int n = 0; n < 1500; n++) begin
			rd(ADDR_CONTROL, v);
			if (v[b] === lvl) return;
		end
		fail_count++;
		$display("CHECK FAILED at %0t: control bit stuck", $time);
		conclude();
	endtask : wait_bit
	task automatic step(input logic [7:0] ctrl, input logic [7:0] st);
		wr(ADDR_CONTROL, ctrl);
		wait_bit(BIT_INT, 1'b1);
		rd(ADDR_STATUS, v);
		chk(v, st);
	endtask : step
	task automatic stop_bus;
		wr(ADDR_CONTROL, 8'h95);
		wait_bit(BIT_STO, 1'b0);
		repeat (4) @(posedge core_clk_i);
		chk({6'h0, scl_oe, sda_oe}, 8'h00);
	endtask : stop_bus

	// ****
	// scenarios
	// ****
	task automatic t_reset;
		rd(ADDR_CONTROL, v);
		chk(v, 8'h00);
		rd(ADDR_STATUS, v);
		chk(v, ST_IDLE);
		wr(2'h3, 8'hff);
		rd(2'h3, v);
		chk(v, 8'h00);
		wr(ADDR_DATA, 8'h5a);
		rd(ADDR_DATA, v);
		chk(v, DATA_RST);
		rd(ADDR_CONTROL, v);
		chk(v, 8'h08);
	endtask : t_reset
	task automatic t_write_read;
		step(8'ha5, ST_START);
		chk({7'h0, irq}, 8'h01);
		wr(ADDR_CONTROL, 8'h25);
		repeat (40) @(posedge core_clk_i);
		rd(ADDR_CONTROL, v);
		chk({v[7], 6'h0, scl_oe}, 8'h81);
		wr(ADDR_DATA, 8'h54);
		step(8'h85, ST_TX_A_ACK);
		wr(ADDR_DATA, 8'h3c);
		chk({7'h0, irq}, 8'h01);
		step(8'h85, ST_TX_D_ACK);
		chk(last_byte, 8'h3c);
		step(8'ha5, ST_RSTART);
		wr(ADDR_DATA, 8'h55);
		step(8'h85, ST_RX_A_ACK);
		step(8'hc5, ST_RX_D_ACK);
		rd(ADDR_DATA, v);
		chk(v, RD_BYTE);
		step(8'h85, ST_RX_D_NACK);
		rd(ADDR_DATA, v);
		chk(v, RD_BYTE);
		stop_bus();
	endtask : t_write_read
	task automatic t_nack;
		step(8'ha5, ST_START);
		wr(ADDR_DATA, 8'h44);
		step(8'h85, ST_TX_A_NACK);
		wr(ADDR_DATA, 8'h11);
		step(8'h85, ST_TX_D_NACK);
		step(8'hb5, ST_START);
		rd(ADDR_CONTROL, v);
		chk({7'h0, v[BIT_STO]}, 8'h00);
		stop_bus();
	endtask : t_nack
	// a second master holds the data line low from the first address bit
	task automatic t_arb;
		for (int k = 0; k < 2; k++) begin
			step(8'ha5, ST_START);
			wr(ADDR_DATA, 8'hfe);
			wr(ADDR_CONTROL, 8'h85);
			tb_low <= 1'b1;
			wait_bit(BIT_INT, 1'b1);
			rd(ADDR_STATUS, v);
			chk(v, ST_ARB);
			wr(ADDR_CONTROL, k == 0 ? 8'h85 : 8'ha5);
			repeat (200) @(posedge core_clk_i);
			rd(ADDR_CONTROL, v);
			chk({v[7], 5'h0, scl_oe, sda_oe}, 8'h00);
			tb_low <= 1'b0;
			if (k == 1) begin
				wait_bit(BIT_INT, 1'b1);
				rd(ADDR_STATUS, v);
				chk(v, ST_START);
				stop_bus();
			end
		end
	endtask : t_arb

	initial begin
		repeat (16) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		t_reset();
		t_write_read();
		t_nack();
		t_arb();
		conclude();
	end
endmodule : tb
